// [include/ledc_cfg.svh]
// constants of the led driver control block
`ifndef LEDC_CFG_SVH
`define LEDC_CFG_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LEDC_CLK_PERIOD_NS 100
`define LEDC_TICK_PERIOD_NS 1000000
`define LEDC_TICK_CYCLES (`LEDC_TICK_PERIOD_NS / `LEDC_CLK_PERIOD_NS)
`define LEDC_FADE_UNIT_MS 8
`define LEDC_SAFETY_MS 1000
`define LEDC_HYST_MS 4
`define LEDC_PUMP_HZ 250000
`define LEDC_PUMP_HALF_CYCLES (1000000000 / (`LEDC_CLK_PERIOD_NS * `LEDC_PUMP_HZ * 2))
// ----------------------------------------------------------------
// code limits and reset values
// ----------------------------------------------------------------
`define LEDC_LOWBIAS_HALFMA 6'h08
`define LEDC_SPOT_MAX 4'h5
`define LEDC_FLASH_MAX 4'he
`define LEDC_FIRST_REGULATOR_MAX 4'h8
`define LEDC_SECOND_REGULATOR_MAX 3'h3
`define LEDC_RST_LEVEL 5'h00
`define LEDC_RST_SINK_EN 4'h0
`define LEDC_RST_TIMER_EN 1'b1
`define LEDC_RST_FADE_RATE 2'h0
`endif

// [include/ledc_pkg.sv]
// types of the led driver control block
package ledc_pkg;
	typedef enum logic [1:0] {
		LEDC_PUMP_1X  = 2'h0,
		LEDC_PUMP_15X = 2'h1,
		LEDC_PUMP_2X  = 2'h3
	} ledc_pump_t;
	typedef enum logic [1:0] {
		LEDC_FADE_IDLE = 2'h0,
		LEDC_FADE_RUN  = 2'h1
	} ledc_fade_t;
endpackage

// [design/ledc_tick.sv]
// millisecond tick divider of the led driver control block
`timescale 1ns/1ps
`default_nettype none
`include "ledc_cfg.svh"
module ledc_tick #(
	parameter int DIV = `LEDC_TICK_CYCLES
) (
	input wire logic ref_clk, // block clock
	input wire logic rst_n, // synchronous reset
	input wire logic run, // low while the internal clock is stopped
	output logic tick // one-cycle pulse per period
);
	logic [15:0] cnt_q, cnt_d;
	logic tick_q, tick_d;

	always_comb begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (!run) begin
			cnt_d = 16'h0000;
		end else if (cnt_q == 16'(DIV - 1)) begin
			cnt_d = 16'h0000;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule // ledc_tick
`default_nettype wire

// [design/ledc_ctrl.sv]
// control logic of the led driver: backlight, fade, flash, pump, regulators
`timescale 1ns/1ps
`default_nettype none
`include "ledc_cfg.svh"
module ledc_ctrl
	import ledc_pkg::*;
#(
	parameter int TICK_DIV = `LEDC_TICK_CYCLES,
	parameter int SAFETY_MS = `LEDC_SAFETY_MS,
	parameter int HYST_MS = `LEDC_HYST_MS
) (
	input wire logic ref_clk, // block clock, 10 MHz
	input wire logic rst_n, // enable pin, low resets all settings
	input wire logic level_wr, // one-cycle strobe with backlight_level_code
	input wire logic [4:0] backlight_level_code, // requested level code
	input wire logic fade_en, // fade enable
	input wire logic [1:0] fade_rate, // fade step rate code
	input wire logic sink_en_wr, // one-cycle strobe with sink_en
	input wire logic [3:0] sink_en, // backlight sink enables
	input wire logic flash_wr, // one-cycle strobe with flash settings
	input wire logic [3:0] flash_code, // flash sink code, zero is off
	input wire logic spot_mode, // 1 spotlight, 0 flash
	input wire logic timer_en, // safety timer enable
	input wire logic ldo_wr, // one-cycle strobe with regulator codes
	input wire logic [3:0] first_regulator_code, // first regulator code
	input wire logic [2:0] second_regulator_code, // second regulator code
	input wire logic flash_trigger_pin, // asynchronous flash trigger
	input wire logic demand_up, // asynchronous pump demand high
	input wire logic demand_down, // asynchronous pump demand low
	output logic [4:0] bl_level, // active backlight code
	output logic [5:0] bl_half_ma, // active current in 0.5 mA units
	output logic [3:0] bl_sink_on, // sink enables
	output logic low_bias, // reduced-bias state
	output logic fade_busy, // fade in progress
	output logic flash_sink_output, // flash sink conducting
	output logic [3:0] flash_50ma, // flash current in 50 mA units
	output logic flash_trip, // safety timer tripped
	output logic sleep, // sleep state
	output logic [1:0] pump_mode, // pump multiplication mode
	output logic pump_clk, // pump switching clock
	output logic [3:0] first_regulator, // first regulator code, 100 mV steps
	output logic [2:0] second_regulator // second regulator code, 100 mV steps
);
	// ----------------------------------------------------------------
	// input synchronisers and tick
	// ----------------------------------------------------------------
	logic [2:0] sync1_q, sync2_q, async_in;
	logic trig_s, up_s, down_s, tick, sleep_q, sleep_d;

	assign async_in = {demand_down, demand_up, flash_trigger_pin};
	generate
		for (genvar gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= async_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate
	assign {down_s, up_s, trig_s} = sync2_q;

	ledc_tick #(.DIV(TICK_DIV)) u_tick (.ref_clk(ref_clk), .rst_n(rst_n), .run(!sleep_q), .tick(tick));

	// ----------------------------------------------------------------
	// settings
	// ----------------------------------------------------------------
	logic [3:0] sink_q, sink_d, fcode_q, fcode_d, first_regulator_q, first_regulator_d;
	logic spot_q, spot_d, ten_q, ten_d;
	logic [2:0] second_regulator_q, second_regulator_d;

	always_comb begin
		sink_d = sink_q;
		fcode_d = fcode_q;
		spot_d = spot_q;
		ten_d = ten_q;
		first_regulator_d = first_regulator_q;
		second_regulator_d = second_regulator_q;
		if (sink_en_wr) sink_d = sink_en;
		if (flash_wr) begin
			spot_d = spot_mode;
			ten_d = timer_en;
			if (spot_mode && flash_code > `LEDC_SPOT_MAX) begin
				fcode_d = `LEDC_SPOT_MAX;
			end else if (flash_code > `LEDC_FLASH_MAX) begin
				fcode_d = `LEDC_FLASH_MAX;
			end else begin
				fcode_d = flash_code;
			end
		end
		if (ldo_wr) begin
			first_regulator_d = (first_regulator_code > `LEDC_FIRST_REGULATOR_MAX) ? `LEDC_FIRST_REGULATOR_MAX : first_regulator_code;
			second_regulator_d = (second_regulator_code > `LEDC_SECOND_REGULATOR_MAX) ? `LEDC_SECOND_REGULATOR_MAX : second_regulator_code;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sink_q <= `LEDC_RST_SINK_EN;
			fcode_q <= 4'h0;
			spot_q <= 1'b0;
			ten_q <= `LEDC_RST_TIMER_EN;
			first_regulator_q <= 4'h0;
			second_regulator_q <= 3'h0;
		end else begin
			sink_q <= sink_d;
			fcode_q <= fcode_d;
			spot_q <= spot_d;
			ten_q <= ten_d;
			first_regulator_q <= first_regulator_d;
			second_regulator_q <= second_regulator_d;
		end
	end

	// ----------------------------------------------------------------
	// backlight level and fade engine
	// ----------------------------------------------------------------
	ledc_fade_t fst_q, fst_d;
	logic [4:0] lvl_q, lvl_d, tgt_q, tgt_d;
	logic [5:0] fms_q, fms_d, fade_int, half_q, half_d;
	logic lowb_q, lowb_d;

	// code to current in 0.5 mA units
	function automatic logic [5:0] ledc_half_ma(input logic [4:0] c);
		if (c < 5'h18) begin
			ledc_half_ma = 6'({1'b0, c}) + 6'h01;
		end else if (c < 5'h1b) begin
			ledc_half_ma = 6'h1a + 6'({c - 5'h18, 1'b0});
		end else begin
			ledc_half_ma = 6'h22 + 6'({c - 5'h1b, 2'b00});
		end
	endfunction

	// 00 gives 32 ms, 11 gives 8 ms
	assign fade_int = 6'({~fade_rate, 3'b000}) + 6'(`LEDC_FADE_UNIT_MS);

	always_comb begin
		fst_d = fst_q;
		lvl_d = lvl_q;
		tgt_d = tgt_q;
		fms_d = fms_q;
		case (fst_q)
			LEDC_FADE_IDLE: begin
				fms_d = 6'h00;
				if (level_wr) begin
					tgt_d = backlight_level_code;
					if (fade_en && backlight_level_code != lvl_q) begin
						fst_d = LEDC_FADE_RUN;
					end else begin
						lvl_d = backlight_level_code;
					end
				end
			end
			LEDC_FADE_RUN: begin
				if (!fade_en) begin
					lvl_d = tgt_q;
					fst_d = LEDC_FADE_IDLE;
				end else if (tick) begin
					if (fms_q + 6'h01 >= fade_int) begin
						fms_d = 6'h00;
						lvl_d = (tgt_q > lvl_q) ? lvl_q + 5'h01 : lvl_q - 5'h01;
						if (lvl_d == tgt_q) begin
							fst_d = LEDC_FADE_IDLE;
						end
					end else begin
						fms_d = fms_q + 6'h01;
					end
				end
			end
			default: fst_d = LEDC_FADE_IDLE;
		endcase
		half_d = ledc_half_ma(lvl_d);
		lowb_d = half_d <= `LEDC_LOWBIAS_HALFMA;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fst_q <= LEDC_FADE_IDLE;
			lvl_q <= `LEDC_RST_LEVEL;
			tgt_q <= `LEDC_RST_LEVEL;
			fms_q <= 6'h00;
			half_q <= 6'h01;
			lowb_q <= 1'b1;
		end else begin
			fst_q <= fst_d;
			lvl_q <= lvl_d;
			tgt_q <= tgt_d;
			fms_q <= fms_d;
			half_q <= half_d;
			lowb_q <= lowb_d;
		end
	end

	// ----------------------------------------------------------------
	// flash sink and safety timer
	// ----------------------------------------------------------------
	logic [15:0] sms_q, sms_d;
	logic trip_q, trip_d, fon_q, fon_d, want;
	logic [3:0] f50_q, f50_d;

	// spotlight runs from the code alone, flash needs the trigger
	assign want = (fcode_q != 4'h0) && (spot_q || trig_s);

	always_comb begin
		sms_d = sms_q;
		trip_d = trip_q;
		if ((fcode_q == 4'h0) || (!spot_q && !trig_s)) begin
			sms_d = 16'h0000;
			trip_d = 1'b0;
		end else if (!ten_q) begin
			sms_d = 16'h0000;
		end else if (fon_q && tick) begin
			if (sms_q == 16'(SAFETY_MS - 1)) begin
				trip_d = 1'b1;
			end else begin
				sms_d = sms_q + 16'h0001;
			end
		end
		fon_d = want && !trip_d;
		f50_d = fon_d ? fcode_d : 4'h0;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sms_q <= 16'h0000;
			trip_q <= 1'b0;
			fon_q <= 1'b0;
			f50_q <= 4'h0;
		end else begin
			sms_q <= sms_d;
			trip_q <= trip_d;
			fon_q <= fon_d;
			f50_q <= f50_d;
		end
	end

	// ----------------------------------------------------------------
	// sleep and charge pump
	// ----------------------------------------------------------------
	ledc_pump_t pm_q, pm_d;
	logic [7:0] hyst_q, hyst_d, pdiv_q, pdiv_d;
	logic pclk_q, pclk_d;

	always_comb begin
		sleep_d = (sink_q == 4'h0) && !fon_q;
		pm_d = pm_q;
		hyst_d = hyst_q;
		if (sleep_q) begin
			pm_d = LEDC_PUMP_1X;
			hyst_d = 8'h00;
		end else if (!(up_s ^ down_s)) begin
			hyst_d = 8'h00;
		end else if (tick) begin
			if (hyst_q == 8'(HYST_MS - 1)) begin
				hyst_d = 8'h00;
				case (pm_q)
					LEDC_PUMP_1X: pm_d = up_s ? LEDC_PUMP_15X : LEDC_PUMP_1X;
					LEDC_PUMP_15X: pm_d = up_s ? LEDC_PUMP_2X : LEDC_PUMP_1X;
					LEDC_PUMP_2X: pm_d = up_s ? LEDC_PUMP_2X : LEDC_PUMP_15X;
					default: pm_d = LEDC_PUMP_1X;
				endcase
			end else begin
				hyst_d = hyst_q + 8'h01;
			end
		end
		pdiv_d = 8'h00;
		pclk_d = 1'b0;
		if (!sleep_q && pm_q != LEDC_PUMP_1X) begin
			if (pdiv_q == 8'(`LEDC_PUMP_HALF_CYCLES - 1)) begin
				pclk_d = !pclk_q;
			end else begin
				pdiv_d = pdiv_q + 8'h01;
				pclk_d = pclk_q;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sleep_q <= 1'b1;
			pm_q <= LEDC_PUMP_1X;
			hyst_q <= 8'h00;
			pdiv_q <= 8'h00;
			pclk_q <= 1'b0;
		end else begin
			sleep_q <= sleep_d;
			pm_q <= pm_d;
			hyst_q <= hyst_d;
			pdiv_q <= pdiv_d;
			pclk_q <= pclk_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign bl_level = lvl_q;
	assign bl_half_ma = half_q;
	assign bl_sink_on = sink_q;
	assign low_bias = lowb_q;
	assign fade_busy = fst_q[0]; // run is the only state with bit 0 set
	assign flash_sink_output = fon_q;
	assign flash_50ma = f50_q;
	assign flash_trip = trip_q;
	assign sleep = sleep_q;
	assign pump_mode = pm_q;
	assign pump_clk = pclk_q;
	assign first_regulator = first_regulator_q;
	assign second_regulator = second_regulator_q;
endmodule // ledc_ctrl
`default_nettype wire

// [verif/ledc_host.sv]
// host model driving the control strobes and pins of the led driver control
`timescale 1ns/1ps
`default_nettype none
module ledc_host (
	input wire logic clk, // block clock
	output logic level_wr, // level strobe
	output logic [4:0] backlight_level_code, // level code
	output logic fade_en, // fade enable
	output logic [1:0] fade_rate, // fade rate
	output logic sink_en_wr, // sink strobe
	output logic [3:0] sink_en, // sink enables
	output logic flash_wr, // flash strobe
	output logic [3:0] flash_code, // flash code
	output logic spot_mode, // spotlight select
	output logic timer_en, // safety timer enable
	output logic ldo_wr, // regulator strobe
	output logic [3:0] first_regulator_code, // first code
	output logic [2:0] second_regulator_code, // second code
	output logic flash_trigger_pin, // flash trigger
	output logic demand_up, // pump demand high
	output logic demand_down // pump demand low
);
	// only two backlight outputs are wired on this board
	localparam logic [3:0] USED = 4'h3;
	initial begin
		{level_wr, backlight_level_code, fade_en, fade_rate, sink_en_wr, sink_en, flash_wr, flash_code} = '0;
		{spot_mode, ldo_wr, first_regulator_code, second_regulator_code, flash_trigger_pin, demand_up, demand_down} = '0;
		timer_en = 1'h1;
	end
	task automatic lvl(input logic [4:0] c);
		@(posedge clk);
		#1 backlight_level_code = c;
		level_wr = 1'h1;
		@(posedge clk);
		#1 level_wr = 1'h0;
	endtask
	task automatic sinks(input logic [3:0] e);
		@(posedge clk);
		#1 sink_en = e & USED;
		sink_en_wr = 1'h1;
		@(posedge clk);
		#1 sink_en_wr = 1'h0;
	endtask
	task automatic flash(input logic [3:0] c, input logic s, input logic t);
		@(posedge clk);
		#1 {flash_code, spot_mode, timer_en} = {c, s, t};
		flash_wr = 1'h1;
		@(posedge clk);
		#1 flash_wr = 1'h0;
	endtask
	task automatic ldo(input logic [3:0] a, input logic [2:0] b);
		@(posedge clk);
		#1 {first_regulator_code, second_regulator_code} = {a, b};
		ldo_wr = 1'h1;
		@(posedge clk);
		#1 ldo_wr = 1'h0;
	endtask
	task automatic pins(input logic t, input logic u, input logic d);
		@(posedge clk);
		#1 {flash_trigger_pin, demand_up, demand_down} = {t, u, d};
	endtask
	task automatic fade(input logic e, input logic [1:0] r);
		@(posedge clk);
		#1 {fade_en, fade_rate} = {e, r};
	endtask
endmodule // ledc_host
`default_nettype wire

// [verif/ledc_ctrl_assertions.sv]
// checker of the led driver control outputs
`timescale 1ns/1ps
`default_nettype none
module ledc_chk
	import ledc_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic rst_n, // reset
	input wire logic flash_wr, // flash strobe
	input wire logic [3:0] flash_code, // flash code
	input wire logic [4:0] bl_level, // level
	input wire logic [5:0] bl_half_ma, // current
	input wire logic low_bias, // bias
	input wire logic fade_busy, // fading
	input wire logic flash_sink_output, // flash on
	input wire logic [3:0] flash_50ma, // flash current
	input wire logic flash_trip, // trip
	input wire logic sleep, // sleep
	input wire logic [1:0] pump_mode, // pump mode
	input wire logic pump_clk, // pump clock
	input wire logic [3:0] bl_sink_on // sinks
);
	function automatic logic [5:0] ma2(input logic [4:0] c);
		if (c < 5'h18) return {1'h0, c} + 6'h01;
		if (c < 5'h1b) return 6'({c, 1'h0}) - 6'h16;
		return 6'({c, 2'h0}) - 6'h4a;
	endfunction
	property p_half;
		@(posedge ref_clk) disable iff (!rst_n) bl_half_ma == ma2(bl_level);
	endproperty
	a_half: assert property (p_half) else $error("current code mismatch");
	property p_bias;
		@(posedge ref_clk) disable iff (!rst_n) low_bias == (bl_half_ma <= 6'h08);
	endproperty
	a_bias: assert property (p_bias) else $error("bias state wrong");
	property p_step;
		@(posedge ref_clk) disable iff (!rst_n) fade_busy && $past(fade_busy) && bl_level != $past(bl_level)
			|-> bl_level == $past(bl_level) + 5'h01 || bl_level == $past(bl_level) - 5'h01;
	endproperty
	a_step: assert property (p_step) else $error("fade skipped a code");
	property p_trip;
		@(posedge ref_clk) disable iff (!rst_n) flash_trip |-> !flash_sink_output;
	endproperty
	a_trip: assert property (p_trip) else $error("flash on while tripped");
	property p_clear;
		@(posedge ref_clk) disable iff (!rst_n) flash_wr && flash_code == 4'h0 |-> ##2 !flash_trip && !flash_sink_output;
	endproperty
	a_clear: assert property (p_clear) else $error("flash not cleared");
	property p_code;
		@(posedge ref_clk) disable iff (!rst_n) flash_50ma <= (flash_sink_output ? 4'he : 4'h0);
	endproperty
	a_code: assert property (p_code) else $error("flash current out of range");
	property p_sleep;
		@(posedge ref_clk) disable iff (!rst_n) sleep && $past(sleep) |-> pump_mode == LEDC_PUMP_1X && !pump_clk;
	endproperty
	a_sleep: assert property (p_sleep) else $error("pump running in sleep");
	property p_still;
		@(posedge ref_clk) disable iff (!rst_n) pump_mode == LEDC_PUMP_1X && $past(pump_mode) == LEDC_PUMP_1X |-> !pump_clk;
	endproperty
	a_still: assert property (p_still) else $error("pump switching in 1x");
	property p_rate;
		@(posedge ref_clk) disable iff (!rst_n) $fell(pump_clk) && pump_mode != LEDC_PUMP_1X
			|-> $past(pump_clk, 20) && !$past(pump_clk, 21);
	endproperty
	a_rate: assert property (p_rate) else $error("pump half period wrong");
	property p_rst;
		@(posedge ref_clk) !rst_n |=> bl_level == 5'h00 && bl_sink_on == 4'h0 && !flash_sink_output;
	endproperty
	a_rst: assert property (p_rst) else $error("settings kept in reset");
endmodule // ledc_chk
bind ledc_ctrl ledc_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .flash_wr(flash_wr), .flash_code(flash_code),
	.bl_level(bl_level), .bl_half_ma(bl_half_ma), .low_bias(low_bias), .fade_busy(fade_busy),
	.flash_sink_output(flash_sink_output), .flash_50ma(flash_50ma), .flash_trip(flash_trip), .sleep(sleep),
	.pump_mode(pump_mode), .pump_clk(pump_clk), .bl_sink_on(bl_sink_on));
`default_nettype wire

// [verif/tb_top.sv]
// testbench of the led driver control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ledc_pkg::*;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic level_wr, fade_en, sink_en_wr, flash_wr, spot_mode, timer_en, ldo_wr, trig, dup, ddn;
	logic [4:0] backlight_level_code, bl_level, old;
	logic [1:0] fade_rate, pump_mode;
	logic [3:0] sink_en, flash_code, first_regulator_code, bl_sink_on, flash_50ma, first_regulator;
	logic [2:0] second_regulator_code, second_regulator;
	logic [5:0] bl_half_ma;
	logic low_bias, fade_busy, flash_sink_output, flash_trip, sleep, pump_clk;
	logic [4:0] cs [8] = '{5'h00, 5'h07, 5'h08, 5'h17, 5'h18, 5'h1a, 5'h1b, 5'h1f};
	logic [5:0] hs [8] = '{6'h01, 6'h08, 6'h09, 6'h18, 6'h1a, 6'h1e, 6'h22, 6'h32};
	int error_cnt = 0;
	int total_checks = 0;
	int n;
	always #50 ref_clk = ~ref_clk;
	ledc_host h (.clk(ref_clk), .level_wr(level_wr), .backlight_level_code(backlight_level_code), .fade_en(fade_en),
		.fade_rate(fade_rate), .sink_en_wr(sink_en_wr), .sink_en(sink_en), .flash_wr(flash_wr),
		.flash_code(flash_code), .spot_mode(spot_mode), .timer_en(timer_en), .ldo_wr(ldo_wr),
		.first_regulator_code(first_regulator_code), .second_regulator_code(second_regulator_code), .flash_trigger_pin(trig), .demand_up(dup), .demand_down(ddn));
	ledc_ctrl #(.TICK_DIV(10), .SAFETY_MS(5), .HYST_MS(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.level_wr(level_wr), .backlight_level_code(backlight_level_code), .fade_en(fade_en), .fade_rate(fade_rate),
		.sink_en_wr(sink_en_wr), .sink_en(sink_en), .flash_wr(flash_wr), .flash_code(flash_code),
		.spot_mode(spot_mode), .timer_en(timer_en), .ldo_wr(ldo_wr), .first_regulator_code(first_regulator_code), .second_regulator_code(second_regulator_code),
		.flash_trigger_pin(trig), .demand_up(dup), .demand_down(ddn), .bl_level(bl_level), .bl_half_ma(bl_half_ma),
		.bl_sink_on(bl_sink_on), .low_bias(low_bias), .fade_busy(fade_busy), .flash_sink_output(flash_sink_output),
		.flash_50ma(flash_50ma), .flash_trip(flash_trip), .sleep(sleep), .pump_mode(pump_mode),
		.pump_clk(pump_clk), .first_regulator(first_regulator), .second_regulator(second_regulator));
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// cycles until the active level moves
	task automatic gap(output int c);
		old = bl_level;
		for (c = 0; c < 400 && bl_level === old; c++) step();
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		#1 rst_n = 1'h1;
		chk({bl_level, bl_half_ma, bl_sink_on, sleep, pump_mode, flash_sink_output}, 19'h00108);
		for (int i = 0; i < 8; i++) begin
			h.lvl(cs[i]);
			chk({bl_half_ma, low_bias}, {hs[i], hs[i] <= 6'h08});
		end
		h.sinks(4'hf);
		chk(bl_sink_on, 4'h3);
		h.lvl(5'h00);
		h.fade(1'h1, 2'h0);
		h.lvl(5'h0a);
		step();
		chk(fade_busy, 1'h1);
		for (int r = 0; r < 4; r++) begin
			h.fade(1'h1, 2'(r));
			gap(n);
			gap(n);
			chk(n, (32 - 8 * r) * 10);
			chk(bl_level, old + 5'h01);
		end
		h.lvl(5'h02);
		for (n = 0; n < 400 && fade_busy !== 1'h0; n++) step();
		chk(bl_level, 5'h0a);
		h.lvl(5'h1f);
		step();
		h.fade(1'h0, 2'h3);
		step();
		chk({bl_level, fade_busy}, {5'h1f, 1'h0});
		h.flash(4'hf, 1'h0, 1'h1);
		h.pins(1'h1, 1'h0, 1'h0);
		for (n = 0; n < 10 && flash_sink_output !== 1'h1; n++) step();
		chk({flash_sink_output, flash_50ma}, {1'h1, 4'he});
		for (n = 0; n < 200 && flash_trip !== 1'h1; n++) step();
		chk(n >= 40 && n <= 60, 1'h1);
		chk({flash_sink_output, bl_sink_on}, {1'h0, 4'h3});
		h.pins(1'h0, 1'h0, 1'h0);
		repeat (4) step();
		chk(flash_trip, 1'h0);
		h.flash(4'h9, 1'h1, 1'h0);
		repeat (3) step();
		chk({flash_sink_output, flash_50ma}, {1'h1, 4'h5});
		repeat (100) step();
		chk({flash_sink_output, flash_trip}, 2'h2);
		h.flash(4'h0, 1'h1, 1'h1);
		step();
		chk(flash_sink_output, 1'h0);
		h.pins(1'h0, 1'h1, 1'h0);
		for (n = 0; n < 200 && pump_mode !== LEDC_PUMP_15X; n++) step();
		chk(n >= 33 && n <= 42, 1'h1);
		for (n = 0; n < 200 && pump_mode !== LEDC_PUMP_2X; n++) step();
		chk(pump_mode, LEDC_PUMP_2X);
		chk(n, 40);
		h.pins(1'h0, 1'h0, 1'h1);
		for (n = 0; n < 400 && pump_mode !== LEDC_PUMP_1X; n++) step();
		step();
		chk({pump_mode, pump_clk}, {LEDC_PUMP_1X, 1'h0});
		h.ldo(4'hf, 3'h7);
		chk({first_regulator, second_regulator}, {4'h8, 3'h3});
		h.ldo(4'h2, 3'h1);
		chk({first_regulator, second_regulator}, {4'h2, 3'h1});
		h.pins(1'h0, 1'h0, 1'h0);
		h.sinks(4'h0);
		step();
		chk({sleep, pump_mode, pump_clk}, {1'h1, 2'h0, 1'h0});
		h.sinks(4'h3);
		rst_n = 1'h0;
		repeat (2) step();
		chk({bl_level, bl_sink_on, first_regulator, second_regulator}, 16'h0000);
		rst_n = 1'h1;
		step();
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
